/* File: rtl/pwr_seq_pkg.sv */
// Constants shared by the power sequencer and its general-purpose pin bank.
// Assumes a 50 MHz system clock; times are converted to cycles here.
package pwr_seq_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned PULSE_US = 1;
  localparam int unsigned PULSE_CYC = PULSE_US * (CLK_HZ / 1000000);
  localparam int unsigned BLINK_MS = 100;
  localparam int unsigned BLINK_CYC = BLINK_MS * (CLK_HZ / 1000);
  localparam int unsigned CPU_MS = 160;
  localparam int unsigned CPU_CYC = CPU_MS * (CLK_HZ / 1000);
  localparam int unsigned SEC_CYC = CLK_HZ;

  // ****************************************************************
  // Fix quality thresholds and pin count
  // ****************************************************************
  localparam logic [3:0] MIN_SATS_PULSE = 4'h5;
  localparam logic [7:0] CN0_LOW = 8'h1a;
  localparam logic [7:0] CN0_HIGH = 8'h1e;
  localparam int unsigned GPIO_N = 5;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_INT_STAT = 8'h08;
  localparam logic [7:0] OFS_INT_MASK = 8'h0c;
  localparam logic [7:0] OFS_STBY_INT = 8'h10;
  localparam logic [7:0] OFS_TRACK = 8'h14;
  localparam logic [7:0] OFS_MAX_ACQ = 8'h18;
  localparam logic [7:0] OFS_GPIO_DIR = 8'h1c;
  localparam logic [7:0] OFS_GPIO_OUT = 8'h20;
  localparam logic [7:0] OFS_GPIO_IN = 8'h24;
  localparam logic [7:0] OFS_GPIO_CFG = 8'h28;

  localparam logic [31:0] RST_STBY_INT = 32'h02faf080;
  localparam logic [31:0] RST_TRACK = 32'h00e4e1c0;
  localparam logic [31:0] RST_MAX_ACQ = 32'h77359400;

  // Interrupt bits.
  localparam int unsigned IRQ_FIX = 0;
  localparam int unsigned IRQ_LOSS = 1;
  localparam int unsigned IRQ_WAKE = 2;
  localparam int unsigned IRQ_FALLBACK = 3;
  localparam int unsigned IRQ_ACQ_TO = 4;

  typedef enum logic [1:0] {
    ST_FULL = 2'b00,
    ST_CPU = 2'b01,
    ST_STBY = 2'b10
  } pwr_state_t;

endpackage : pwr_seq_pkg

/* File: rtl/gpio_bank.sv */
// General-purpose pin bank: direction, output level and synchronised input levels.
// Assumes pins are driven by the bench from dir/out/oe; inputs are asynchronous.
`timescale 1ns/1ps
module gpio_bank (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Command strobes from the register file
  input wire logic dir_we_i,
  input wire logic out_we_i,
  input wire logic [4:0] wdata_i,
  // Pins
  input wire logic [4:0] pin_i,
  output logic [4:0] pin_o,
  output logic [4:0] pin_oe_n_o,
  // State readback
  output logic [4:0] dir_o,
  output logic [4:0] in_o
);

  logic [4:0] dir_q;
  logic [4:0] out_q;
  logic [4:0] meta_q;
  logic [4:0] sync_q;

  // ****************************************************************
  // Direction and output level
  // ****************************************************************
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dir_q <= 5'h00;
      out_q <= 5'h00;
    end else begin
      if (dir_we_i) begin
        dir_q <= wdata_i;
      end
      if (out_we_i) begin
        out_q <= wdata_i;
      end
    end
  end

  // ****************************************************************
  // Input synchroniser
  // ****************************************************************
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= 5'h00;
      sync_q <= 5'h00;
    end else begin
      meta_q <= pin_i;
      sync_q <= meta_q;
    end
  end

  // Enable low means drive; pins start as inputs so nothing fights at power-up.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_o <= 5'h00;
      pin_oe_n_o <= 5'h1f;
      dir_o <= 5'h00;
      in_o <= 5'h00;
    end else begin
      pin_o <= out_q;
      pin_oe_n_o <= ~dir_q;
      dir_o <= dir_q;
      in_o <= sync_q;
    end
  end

endmodule : gpio_bank

/* File: rtl/pwr_seq.sv */
// Power state sequencer with second pulse, fix indicator, interrupt and pin bank.
// Assumes navigation status inputs come from logic on clk_sys_i; the wake pin is async.
//
// What this block does
// - Second pulse on each second while five or more satellites fix.
// - Second pulse lasts one microsecond from the tick.
// - Second pulse low until a fix with over four satellites.
// - Searching: indicator toggles 100 ms high, 100 ms low.
// - Fixed: indicator gives one 100 ms pulse each second.
// - Start in full power until a reliable fix.
// - Duty mode after fix: RF off, CPU 160 ms, standby.
// - Standby wakes after interval, tracks, CPU, standby again.
// - Programmable limit on initial acquisition in duty mode.
// - Full power when fourth strongest is below 26 dB-Hz.
// - Duty mode resumes when fourth strongest exceeds 30 dB-Hz.
// - Stay full while collecting data or refining.
// - CPU-only when measurements done, solution pending.
// - Five pins: direction, read, write, report all.
// - Standby: RF off, baseband clock stopped.
// - Power state output high except in standby.
// - Wake input edge acts while power state is low.
`timescale 1ns/1ps
module pwr_seq (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [7:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Navigation core status
  input wire logic fix_valid_i,
  input wire logic [3:0] sat_count_i,
  input wire logic [7:0] cn0_fourth_i,
  input wire logic meas_done_i,
  input wire logic nav_done_i,
  input wire logic hold_full_i,
  input wire logic gps_second_i,
  // Wake pin
  input wire logic wake_pin_i,
  // Pins and power controls
  output logic second_pulse_out_o,
  output logic fix_indicator_out_o,
  output logic rf_power_state_out_o,
  output logic rf_enable_o,
  output logic baseband_clk_en_o,
  output logic irq_o,
  // General-purpose pins
  input wire logic [4:0] gpio_i,
  output logic [4:0] gpio_o,
  output logic [4:0] gpio_oe_n_o
);

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic duty_en_q;
  logic [31:0] stby_int_q;
  logic [31:0] track_q;
  logic [31:0] max_acq_q;
  logic [4:0] irq_stat_q;
  logic [4:0] irq_mask_q;
  logic [4:0] irq_set;
  logic [4:0] gpio_dir;
  logic [4:0] gpio_in;
  logic rd_stat_clr;
  logic addr_ok;
  pwr_seq_pkg::pwr_state_t state_q;
  logic low_sig_q;
  logic ever_locked_q;

  wire logic addr_phase = hsel_i && hready_i && htrans_i[1];
  wire logic wr_ctrl = wr_pend_q && (wr_addr_q == pwr_seq_pkg::OFS_CTRL);

  function automatic logic decode_ok(input logic [7:0] a);
    decode_ok = (a[1:0] == 2'b00) && (a <= pwr_seq_pkg::OFS_GPIO_CFG);
  endfunction : decode_ok

  assign addr_ok = decode_ok(haddr_i);
  assign rd_stat_clr = addr_phase && !hwrite_i && (haddr_i == pwr_seq_pkg::OFS_INT_STAT);

  // Zero-wait slave: write data are captured in the cycle after the address.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= addr_phase && hwrite_i && addr_ok;
      wr_addr_q <= haddr_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      duty_en_q <= 1'b0;
      stby_int_q <= pwr_seq_pkg::RST_STBY_INT;
      track_q <= pwr_seq_pkg::RST_TRACK;
      max_acq_q <= pwr_seq_pkg::RST_MAX_ACQ;
      irq_mask_q <= 5'h00;
    end else if (wr_pend_q) begin
      if (wr_addr_q == pwr_seq_pkg::OFS_CTRL) begin
        duty_en_q <= hwdata_i[0];
      end else if (wr_addr_q == pwr_seq_pkg::OFS_INT_MASK) begin
        irq_mask_q <= hwdata_i[4:0];
      end else if (wr_addr_q == pwr_seq_pkg::OFS_STBY_INT) begin
        stby_int_q <= hwdata_i;
      end else if (wr_addr_q == pwr_seq_pkg::OFS_TRACK) begin
        track_q <= hwdata_i;
      end else if (wr_addr_q == pwr_seq_pkg::OFS_MAX_ACQ) begin
        max_acq_q <= hwdata_i;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hrdata_o <= 32'h00000000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      if (addr_phase && !hwrite_i) begin
        if (haddr_i == pwr_seq_pkg::OFS_CTRL) begin
          hrdata_o <= {31'h00000000, duty_en_q};
        end else if (haddr_i == pwr_seq_pkg::OFS_STATUS) begin
          hrdata_o <= {27'h0, ever_locked_q, low_sig_q, rf_power_state_out_o, state_q};
        end else if (haddr_i == pwr_seq_pkg::OFS_INT_STAT) begin
          hrdata_o <= {27'h0, irq_stat_q};
        end else if (haddr_i == pwr_seq_pkg::OFS_INT_MASK) begin
          hrdata_o <= {27'h0, irq_mask_q};
        end else if (haddr_i == pwr_seq_pkg::OFS_STBY_INT) begin
          hrdata_o <= stby_int_q;
        end else if (haddr_i == pwr_seq_pkg::OFS_TRACK) begin
          hrdata_o <= track_q;
        end else if (haddr_i == pwr_seq_pkg::OFS_MAX_ACQ) begin
          hrdata_o <= max_acq_q;
        end else if (haddr_i == pwr_seq_pkg::OFS_GPIO_DIR) begin
          hrdata_o <= {27'h0, gpio_dir};
        end else if (haddr_i == pwr_seq_pkg::OFS_GPIO_OUT) begin
          hrdata_o <= {27'h0, gpio_o};
        end else if (haddr_i == pwr_seq_pkg::OFS_GPIO_IN) begin
          hrdata_o <= {27'h0, gpio_in};
        end else if (haddr_i == pwr_seq_pkg::OFS_GPIO_CFG) begin
          hrdata_o <= {14'h0, gpio_o, 3'h0, gpio_dir, gpio_in};
        end else begin
          hrdata_o <= 32'h0;
        end
      end
    end
  end

  // ****************************************************************
  // Pin bank
  // ****************************************************************
  gpio_bank u_gpio (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .dir_we_i(wr_pend_q && (wr_addr_q == pwr_seq_pkg::OFS_GPIO_DIR)),
    .out_we_i(wr_pend_q && (wr_addr_q == pwr_seq_pkg::OFS_GPIO_OUT)),
    .wdata_i(hwdata_i[4:0]),
    .pin_i(gpio_i),
    .pin_o(gpio_o),
    .pin_oe_n_o(gpio_oe_n_o),
    .dir_o(gpio_dir),
    .in_o(gpio_in)
  );

  // ****************************************************************
  // Wake pin and second tick
  // ****************************************************************
  logic wake_meta_q;
  logic wake_sync_q;
  logic wake_prev_q;
  logic sec_prev_q;
  wire logic wake_edge = wake_sync_q && !wake_prev_q;
  // One tick feeds both the pulse and the indicator so they never drift apart.
  wire logic sec_tick = gps_second_i && !sec_prev_q;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wake_meta_q <= 1'b0;
      wake_sync_q <= 1'b0;
      wake_prev_q <= 1'b0;
      sec_prev_q <= 1'b0;
    end else begin
      wake_meta_q <= wake_pin_i;
      wake_sync_q <= wake_meta_q;
      wake_prev_q <= wake_sync_q;
      sec_prev_q <= gps_second_i;
    end
  end

  // ****************************************************************
  // Second pulse
  // ****************************************************************
  logic [5:0] pps_cnt_q;
  wire logic over_solved = fix_valid_i && (sat_count_i >= pwr_seq_pkg::MIN_SATS_PULSE);

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ever_locked_q <= 1'b0;
    end else if (over_solved) begin
      ever_locked_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pps_cnt_q <= 6'h00;
      second_pulse_out_o <= 1'b0;
    end else if (sec_tick && over_solved) begin
      pps_cnt_q <= 6'(pwr_seq_pkg::PULSE_CYC - 1);
      second_pulse_out_o <= 1'b1;
    end else if (pps_cnt_q != 6'h00) begin
      pps_cnt_q <= pps_cnt_q - 6'h01;
    end else begin
      second_pulse_out_o <= 1'b0;
    end
  end

  // ****************************************************************
  // Fix indicator
  // ****************************************************************
  logic [22:0] blink_cnt_q;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      blink_cnt_q <= 23'h000000;
      fix_indicator_out_o <= 1'b0;
    end else if (fix_valid_i) begin
      if (sec_tick) begin
        blink_cnt_q <= 23'(pwr_seq_pkg::BLINK_CYC - 1);
        fix_indicator_out_o <= 1'b1;
      end else if (blink_cnt_q != 23'h000000) begin
        blink_cnt_q <= blink_cnt_q - 23'h000001;
      end else begin
        fix_indicator_out_o <= 1'b0;
      end
    end else if (blink_cnt_q == 23'h000000) begin
      blink_cnt_q <= 23'(pwr_seq_pkg::BLINK_CYC - 1);
      fix_indicator_out_o <= !fix_indicator_out_o;
    end else begin
      blink_cnt_q <= blink_cnt_q - 23'h000001;
    end
  end

  // ****************************************************************
  // Signal strength hysteresis
  // ****************************************************************
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_sig_q <= 1'b0;
    end else if (cn0_fourth_i < pwr_seq_pkg::CN0_LOW) begin
      low_sig_q <= 1'b1;
    end else if (cn0_fourth_i > pwr_seq_pkg::CN0_HIGH) begin
      low_sig_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Power state machine
  // ****************************************************************
  logic [31:0] tmr_q;
  logic [31:0] acq_q;
  logic fix_seen_q;
  logic acq_to;
  wire logic stay_full = low_sig_q || hold_full_i || !duty_en_q;

  assign acq_to = (acq_q >= max_acq_q) && !fix_seen_q;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= pwr_seq_pkg::ST_FULL;
      tmr_q <= 32'h00000000;
      acq_q <= 32'h00000000;
      fix_seen_q <= 1'b0;
    end else begin
      if (!fix_seen_q && state_q == pwr_seq_pkg::ST_FULL && !acq_to) begin
        acq_q <= acq_q + 32'h00000001;
      end
      if (fix_valid_i) begin
        fix_seen_q <= 1'b1;
      end
      case (state_q)
        pwr_seq_pkg::ST_FULL: begin
          tmr_q <= tmr_q + 32'h00000001;
          // The acquisition limit abandons a hopeless search and sleeps to save charge.
          if (duty_en_q && acq_to) begin
            state_q <= pwr_seq_pkg::ST_STBY;
            tmr_q <= 32'h00000000;
          end else if (fix_valid_i && !stay_full && meas_done_i &&
                       (tmr_q >= track_q || !fix_seen_q)) begin
            state_q <= pwr_seq_pkg::ST_CPU;
            tmr_q <= 32'h00000000;
          end
        end
        pwr_seq_pkg::ST_CPU: begin
          tmr_q <= tmr_q + 32'h00000001;
          if (stay_full) begin
            state_q <= pwr_seq_pkg::ST_FULL;
            tmr_q <= 32'h00000000;
          end else if (nav_done_i || tmr_q >= 32'(pwr_seq_pkg::CPU_CYC - 1)) begin
            state_q <= pwr_seq_pkg::ST_STBY;
            tmr_q <= 32'h00000000;
          end
        end
        pwr_seq_pkg::ST_STBY: begin
          tmr_q <= tmr_q + 32'h00000001;
          if (wake_edge || tmr_q >= stby_int_q || stay_full) begin
            state_q <= pwr_seq_pkg::ST_FULL;
            tmr_q <= 32'h00000000;
            acq_q <= 32'h00000000;
          end
        end
        default: begin
          state_q <= pwr_seq_pkg::ST_FULL;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rf_power_state_out_o <= 1'b1;
      rf_enable_o <= 1'b1;
      baseband_clk_en_o <= 1'b1;
    end else begin
      rf_power_state_out_o <= (state_q != pwr_seq_pkg::ST_STBY);
      rf_enable_o <= (state_q == pwr_seq_pkg::ST_FULL);
      baseband_clk_en_o <= (state_q != pwr_seq_pkg::ST_STBY);
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  logic fix_prev_q;
  logic low_prev_q;
  logic stby_prev_q;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fix_prev_q <= 1'b0;
      low_prev_q <= 1'b0;
      stby_prev_q <= 1'b0;
    end else begin
      fix_prev_q <= fix_valid_i;
      low_prev_q <= low_sig_q;
      stby_prev_q <= (state_q == pwr_seq_pkg::ST_STBY);
    end
  end

  always_comb begin
    irq_set = 5'h00;
    irq_set[pwr_seq_pkg::IRQ_FIX] = fix_valid_i && !fix_prev_q;
    irq_set[pwr_seq_pkg::IRQ_LOSS] = !fix_valid_i && fix_prev_q;
    irq_set[pwr_seq_pkg::IRQ_WAKE] = stby_prev_q && (state_q != pwr_seq_pkg::ST_STBY);
    irq_set[pwr_seq_pkg::IRQ_FALLBACK] = low_sig_q && !low_prev_q;
    irq_set[pwr_seq_pkg::IRQ_ACQ_TO] = acq_to && (acq_q == max_acq_q) && duty_en_q;
  end

  // A new event in the clearing read's cycle survives the clear.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_stat_q <= 5'h00;
      irq_o <= 1'b0;
    end else begin
      irq_stat_q <= (rd_stat_clr ? 5'h00 : irq_stat_q) | irq_set;
      irq_o <= |(irq_stat_q & irq_mask_q);
    end
  end

  logic unused_ok;
  assign unused_ok = wr_ctrl ^ (|hsize_i);

endmodule : pwr_seq

/* File: sim/pwr_seq_props.sv */
// Checker for the second pulse and power state outputs of the sequencer.
// Assumes one clock domain; sees only the top module's ports.
`timescale 1ns/1ps
module pwr_seq_props (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Observed ports
  input wire logic fix_valid_i,
  input wire logic [3:0] sat_count_i,
  input wire logic [7:0] cn0_fourth_i,
  input wire logic meas_done_i,
  input wire logic hold_full_i,
  input wire logic gps_second_i,
  input wire logic wake_pin_i,
  input wire logic second_pulse_out_o,
  input wire logic rf_power_state_out_o,
  input wire logic rf_enable_o,
  input wire logic baseband_clk_en_o
);
  // ****************************************************************
  // Helper logic and properties
  // ****************************************************************
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  logic sec_q;
  logic ever_q;
  logic [7:0] hi_q;
  wire logic good = fix_valid_i && (sat_count_i >= pwr_seq_pkg::MIN_SATS_PULSE);
  wire logic qual = gps_second_i && !sec_q && good;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sec_q <= 1'b0;
      ever_q <= 1'b0;
      hi_q <= 8'h00;
    end else begin
      sec_q <= gps_second_i;
      ever_q <= ever_q | good;
      hi_q <= second_pulse_out_o ? hi_q + 8'h01 : 8'h00;
    end
  end
  pulse_cause_a: assert property ($rose(second_pulse_out_o) |->
    $past(qual) || $past(qual, 2) || $past(qual, 3)) else $error("stray pulse");
  pulse_follow_a: assert property (qual |-> ##[1:3] $rose(second_pulse_out_o))
    else $error("no pulse");
  pulse_max_a: assert property (second_pulse_out_o |-> hi_q < pwr_seq_pkg::PULSE_CYC)
    else $error("pulse long");
  pulse_len_a: assert property ($fell(second_pulse_out_o) |-> hi_q == pwr_seq_pkg::PULSE_CYC)
    else $error("pulse short");
  dark_start_a: assert property (!ever_q |-> !second_pulse_out_o)
    else $error("early pulse");
  start_full_a: assert property ($rose(rst_n_i) |-> rf_enable_o && baseband_clk_en_o)
    else $error("not full");
  low_signal_a: assert property ((cn0_fourth_i < pwr_seq_pkg::CN0_LOW)[*2] |->
    ##[0:4] rf_enable_o) else $error("weak not full");
  hold_full_a: assert property (hold_full_i[*2] |-> ##[0:4] rf_enable_o)
    else $error("hold not full");
  cpu_entry_a: assert property ($fell(rf_enable_o) && baseband_clk_en_o |->
    $past(meas_done_i) || $past(meas_done_i, 2)) else $error("early cpu");
  stby_rf_a: assert property (!baseband_clk_en_o |-> !rf_enable_o)
    else $error("rf in standby");
  rf_state_a: assert property ($fell(baseband_clk_en_o) |-> ##[0:1] !rf_power_state_out_o)
    else $error("state pin high");
  wake_a: assert property ($rose(wake_pin_i) && !rf_power_state_out_o |->
    ##[2:6] rf_enable_o) else $error("wake ignored");
  cover property ($rose(second_pulse_out_o));
  cover property ($fell(rf_enable_o) && baseband_clk_en_o);
  cover property ($fell(baseband_clk_en_o));
endmodule : pwr_seq_props

bind pwr_seq pwr_seq_props u_props (.*);

/* File: sim/nav_host_model.sv */
// Host stand-in: makes the second tick, pulses the wake pin and loads the pins.
// Assumes one clock; the bench drives the navigation status inputs itself.
`timescale 1ns/1ps
module nav_host_model #(
  parameter int unsigned SEC_PERIOD = 200
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Requests from the bench
  input wire logic wake_req_i,
  input wire logic [4:0] ext_level_i,
  // Device pins
  input wire logic rf_power_state_out_i,
  input wire logic [4:0] pin_drive_i,
  input wire logic [4:0] pin_oe_n_i,
  output logic gps_second_o,
  output logic wake_pin_o,
  output logic [4:0] pin_level_o
);
  // ****************************************************************
  // Tick, wake and pins
  // ****************************************************************
  logic [15:0] sec_cnt_q;
  logic [2:0] wake_cnt_q;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sec_cnt_q <= 16'h0000;
    end else begin
      sec_cnt_q <= (sec_cnt_q == 16'(SEC_PERIOD - 1)) ? 16'h0000 : sec_cnt_q + 16'h0001;
    end
  end
  assign gps_second_o = sec_cnt_q < 16'(SEC_PERIOD / 2);
  // A wake edge is only offered while the device reports standby.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wake_cnt_q <= 3'h0;
    end else if (wake_req_i && !rf_power_state_out_i && wake_cnt_q == 3'h0) begin
      wake_cnt_q <= 3'h7;
    end else if (wake_cnt_q != 3'h0) begin
      wake_cnt_q <= wake_cnt_q - 3'h1;
    end
  end
  assign wake_pin_o = wake_cnt_q != 3'h0;
  // A pin the device drives shows its level; others carry the host's level.
  assign pin_level_o = (~pin_oe_n_i & pin_drive_i) | (pin_oe_n_i & ext_level_i);
endmodule : nav_host_model

/* File: sim/gps_power_state_and_status_outputs_tb.sv */
// Bench for the power sequencer: bus tasks and sequences of calls.
// Assumes the host model file and the checker file are compiled with it.
`timescale 1ns/1ps
module gps_power_state_and_status_outputs_tb;
  // ****************************************************************
  // Signals, instances and tasks
  // ****************************************************************
  localparam logic [2:0] FULL = 3'b111;
  localparam logic [2:0] CPU = 3'b011;
  localparam logic [2:0] STBY = 3'b000;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic hsel_i = 1'b1;
  logic [7:0] haddr_i = 8'h00;
  logic [1:0] htrans_i = 2'b00;
  logic hwrite_i = 1'b0;
  logic [2:0] hsize_i = 3'h2;
  logic [31:0] hwdata_i = 32'h0;
  logic [31:0] hrdata_o;
  logic [31:0] rd;
  logic hreadyout_o, hresp_o, gps_second_i, wake_pin_i, wake_req = 1'b0;
  logic fix_valid_i = 1'b0, meas_done_i = 1'b0, nav_done_i = 1'b0, hold_full_i = 1'b0;
  logic [3:0] sat_count_i = 4'h0;
  logic [7:0] cn0_fourth_i = 8'h28;
  logic second_pulse_out_o, fix_indicator_out_o, rf_power_state_out_o;
  logic rf_enable_o, baseband_clk_en_o, irq_o;
  logic [4:0] gpio_i, gpio_o, gpio_oe_n_o;
  int fail_count = 0;
  int check_count = 0;
  int pulses = 0;
  int hi_len = 0;
  int last_len = 0;
  always #10 clk_sys_i = ~clk_sys_i;
  pwr_seq dut_u (.*, .hready_i(hreadyout_o));
  nav_host_model host_u (.clk_sys_i, .rst_n_i, .wake_req_i(wake_req), .ext_level_i(5'h15),
    .rf_power_state_out_i(rf_power_state_out_o), .pin_drive_i(gpio_o),
    .pin_oe_n_i(gpio_oe_n_o), .gps_second_o(gps_second_i), .wake_pin_o(wake_pin_i),
    .pin_level_o(gpio_i));
  // Widths are measured here so a short pulse cannot hide between bus calls.
  always @(posedge clk_sys_i) begin
    if (second_pulse_out_o === 1'b1) begin
      pulses <= (hi_len == 0) ? pulses + 1 : pulses;
      hi_len <= hi_len + 1;
    end else begin
      last_len <= (hi_len != 0) ? hi_len : last_len;
      hi_len <= 0;
    end
  end
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_sys_i);
    haddr_i <= a;
    hwrite_i <= wr;
    htrans_i <= 2'b10;
    do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'b00;
    hwdata_i <= wd;
    do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
  endtask : bus
  task rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask : rdchk
  task wait_st(input string what, input logic [2:0] exp, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while ({rf_enable_o, baseband_clk_en_o, rf_power_state_out_o} !== exp && n < lim);
    chk(what, {29'h0, exp}, {29'h0, rf_enable_o, baseband_clk_en_o, rf_power_state_out_o});
  endtask : wait_st
  task final_report;
    $display("checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report
  initial begin
    #(20 * 40000);
    fail_count++;
    final_report();
  end
  initial begin
    repeat (12) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    wait_st("reset state", FULL, 1);
    chk("pulse", 32'h0, {31'h0, second_pulse_out_o});
    chk("pin oe", 32'h1f, {27'h0, gpio_oe_n_o});
    rdchk("interval", pwr_seq_pkg::OFS_STBY_INT, pwr_seq_pkg::RST_STBY_INT);
    rdchk("track", pwr_seq_pkg::OFS_TRACK, pwr_seq_pkg::RST_TRACK);
    rdchk("acq limit", pwr_seq_pkg::OFS_MAX_ACQ, pwr_seq_pkg::RST_MAX_ACQ);
    rdchk("unmapped", 8'h2c, 32'h0);
    chk("hresp", 32'h0, {31'h0, hresp_o});
    chk("led search", 32'h1, {31'h0, fix_indicator_out_o});
    bus(1'b1, pwr_seq_pkg::OFS_INT_MASK, 32'h1);
    fix_valid_i <= 1'b1;
    sat_count_i <= 4'h4;
    repeat (500) @(posedge clk_sys_i);
    chk("pulses four", 32'h0, pulses);
    chk("irq", 32'h1, {31'h0, irq_o});
    rdchk("fix event", pwr_seq_pkg::OFS_INT_STAT, 32'h1);
    repeat (3) @(posedge clk_sys_i);
    chk("irq clear", 32'h0, {31'h0, irq_o});
    sat_count_i <= 4'h5;
    repeat (450) @(posedge clk_sys_i);
    chk("pulses five", 32'h1, {31'h0, pulses >= 2});
    chk("pulse len", pwr_seq_pkg::PULSE_CYC, last_len);
    chk("led fix", 32'h1, {31'h0, fix_indicator_out_o});
    bus(1'b1, pwr_seq_pkg::OFS_INT_MASK, 32'h0);
    fix_valid_i <= 1'b0;
    repeat (5) @(posedge clk_sys_i);
    chk("masked irq", 32'h0, {31'h0, irq_o});
    rdchk("loss event", pwr_seq_pkg::OFS_INT_STAT, 32'h2);
    fix_valid_i <= 1'b1;
    bus(1'b1, pwr_seq_pkg::OFS_STBY_INT, 32'd100);
    bus(1'b1, pwr_seq_pkg::OFS_TRACK, 32'd30);
    meas_done_i <= 1'b1;
    bus(1'b1, pwr_seq_pkg::OFS_CTRL, 32'h1);
    wait_st("cpu", CPU, 60);
    nav_done_i <= 1'b1;
    wait_st("standby", STBY, 60);
    wait_st("interval wake", FULL, 200);
    wait_st("track cpu", CPU, 200);
    nav_done_i <= 1'b0;
    cn0_fourth_i <= 8'd20;
    wait_st("weak", FULL, 20);
    cn0_fourth_i <= 8'd28;
    repeat (200) @(posedge clk_sys_i);
    wait_st("hysteresis", FULL, 1);
    cn0_fourth_i <= 8'd35;
    wait_st("duty again", CPU, 200);
    hold_full_i <= 1'b1;
    wait_st("held", FULL, 20);
    bus(1'b1, pwr_seq_pkg::OFS_STBY_INT, 32'h00100000);
    hold_full_i <= 1'b0;
    nav_done_i <= 1'b1;
    wait_st("long standby", STBY, 300);
    wake_req <= 1'b1;
    @(posedge clk_sys_i);
    wake_req <= 1'b0;
    wait_st("pin wake", FULL, 12);
    rst_n_i <= 1'b0;
    fix_valid_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    wait_st("reset state", FULL, 1);
    bus(1'b1, pwr_seq_pkg::OFS_MAX_ACQ, 32'd1000);
    bus(1'b1, pwr_seq_pkg::OFS_CTRL, 32'h1);
    wait_st("acq limit", STBY, 3000);
    rdchk("acq event", pwr_seq_pkg::OFS_INT_STAT, 32'h10);
    bus(1'b1, pwr_seq_pkg::OFS_GPIO_DIR, 32'h3);
    bus(1'b1, pwr_seq_pkg::OFS_GPIO_OUT, 32'h1);
    repeat (3) @(posedge clk_sys_i);
    chk("pin oe", 32'h1c, {27'h0, gpio_oe_n_o});
    chk("pin levels", 32'h1, {30'h0, gpio_o[1:0]});
    rdchk("pin inputs", pwr_seq_pkg::OFS_GPIO_IN, 32'h15);
    rdchk("pin report", pwr_seq_pkg::OFS_GPIO_CFG, 32'h2075);
    final_report();
  end
endmodule : gps_power_state_and_status_outputs_tb
